// [ccs_pkg.sv]
/*
  Package for the configuration control sequencer, plus the serial clock
  divider that the sequencer instantiates.
  Assumes a single 100 MHz system clock standing in for the internal
  configuration oscillator, and an asynchronous active-high reset.
*/
`default_nettype none

package ccs_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPI_PWR_DELAY_US = 100;
  localparam int SPI_PWR_DELAY_CYC =
    (SPI_PWR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] WAKE_CYCLES = 6'h31;
  localparam logic [3:0] SCK_HALF_SLOW = 4'h4;
  localparam logic [3:0] SCK_HALF_FAST = 4'h2;
  localparam logic [31:0] FAST_FLAG_BIT = 32'h0000_0007;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LEN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BITCNT = 8'h0c;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int CTRL_OTP_EN = 0;
  localparam int CTRL_FORCE_SLOW = 1;
  localparam logic [31:0] LEN_RST = 32'h0000_0100;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_FAST = 2;
  localparam int ST_DONE = 3;
  localparam int ST_PIO = 4;
  localparam int ST_STATE_LSB = 8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_NONE, MODE_MASTER, MODE_OTP, MODE_SLAVE
  } ccs_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD, ST_LOAD, ST_WAKE, ST_USER
  } ccs_state_t;
endpackage : ccs_pkg

// ============================================================
// serial clock divider: equal high and low halves
module ccs_sck_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic fast,
  // clock and edge pulses
  output logic sck_q,
  output logic rise_q,
  output logic fall_q
);
  logic [3:0] cnt_q, cnt_d;
  logic sck_d, rise_d, fall_d, fast_q, fast_d;
  logic [3:0] half;
  logic toggle;

  always_comb begin
    half = fast_q ? ccs_pkg::SCK_HALF_FAST : ccs_pkg::SCK_HALF_SLOW;
    toggle = run && (cnt_q == half - 4'h1);
    cnt_d = toggle ? 4'h0 : (run ? cnt_q + 4'h1 : 4'h0);
    sck_d = run ? (toggle ? !sck_q : sck_q) : 1'b0;
    rise_d = toggle && !sck_q;
    fall_d = toggle && sck_q;
    // speed changes only at a falling edge or while stopped, so no half is ever cut short
    fast_d = (!run || (toggle && sck_q)) ? fast : fast_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      sck_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sck_q <= sck_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      fast_q <= fast_d;
    end
  end
endmodule : ccs_sck_div

`default_nettype wire

// [ccs_config_seq.sv]
/*
  Configuration control sequencer: power-good and reset qualification,
  mode selection, configuration clocking, completion and I/O release,
  with an APB register slave.
  Assumes ccs_pkg.sv is compiled first; pins from outside arrive
  asynchronously and are synchronised here; the on-chip one-time memory
  runs on CLK.
*/
// The APB register port and the address map are this design's own decisions.
`default_nettype none

// What this block does
// - config reset low keeps the sequencer in reset; the APB registers keep their values
// - config reset rising restarts configuration as from cold power-up
// - completion releases the done pull-down so the pin floats high
// - programmable I/O enabled 49 configuration clocks after completion
// - master flash and one-time memory modes clock from internal oscillator
// - slave mode clocks configuration from the external serial clock
// - oscillator starts slow; a bitstream flag may switch it fast
// - oscillator and flash serial clock have equal high and low time
// - held in reset until every supply-good indication is high
// - extra timeout after flash supply good before reset release
// - configuration begins only once power-on reset is released
// - master mode drives serial clock and select to the flash
// - slave-select pin sampled on reset exit chooses self-load or slave
// - self-load uses enabled programmed one-time memory, else flash
module ccs_config_seq #(
  parameter int SPI_PWR_DELAY_CYC = ccs_pkg::SPI_PWR_DELAY_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // supply monitors and reset pin
  input wire logic VCC_GOOD,
  input wire logic SPI_VCC_GOOD,
  input wire logic IO_VCC_GOOD,
  input wire logic VPP_GOOD,
  input wire logic CONFIG_RESET_N,
  // open-drain completion pin
  output logic CONFIG_COMPLETE_O,
  output logic CONFIG_COMPLETE_OE,
  // serial configuration pins
  input wire logic SS_I,
  output logic SS_O,
  output logic SS_OE,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic SI,
  // on-chip one-time memory
  input wire logic OTP_PROGRAMMED,
  input wire logic OTP_BIT,
  output logic OTP_NEXT,
  // configuration data and user release
  output logic CFG_BIT,
  output logic CFG_BIT_VLD,
  output logic PROGRAMMABLE_IO_EN
);
  // ==========================================================
  // helpers
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ccs_pkg::ADDR_CTRL) || (a == ccs_pkg::ADDR_LEN) ||
               (a == ccs_pkg::ADDR_STATUS) || (a == ccs_pkg::ADDR_BITCNT);
  endfunction : addr_hit

  // ==========================================================
  // pin synchronisers
  // bit order: 7 reset_n, 6..3 supplies, 2 ss, 1 sck, 0 si
  logic [7:0] pin_s1_q, pin_s2_q;
  logic sck_s3_q;
  logic cfg_rst_n_s, sup_all_s, spi_good_s, ss_s, sck_s, si_s;
  logic sck_rise;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      sck_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {CONFIG_RESET_N, VCC_GOOD, SPI_VCC_GOOD, IO_VCC_GOOD,
                   VPP_GOOD, SS_I, SCK_I, SI};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= pin_s2_q[1];
    end
  end

  always_comb begin
    cfg_rst_n_s = pin_s2_q[7];
    sup_all_s = &pin_s2_q[6:3];
    spi_good_s = pin_s2_q[5];
    ss_s = pin_s2_q[2];
    sck_s = pin_s2_q[1];
    si_s = pin_s2_q[0];
    sck_rise = sck_s && !sck_s3_q;
  end

  // ==========================================================
  // flash supply power-up timeout
  logic [23:0] pwr_cnt_q, pwr_cnt_d;
  logic pwr_ok_q, pwr_ok_d;

  always_comb begin
    pwr_cnt_d = pwr_cnt_q;
    pwr_ok_d = pwr_ok_q;
    if (!spi_good_s) begin
      pwr_cnt_d = 24'h000000;
      pwr_ok_d = 1'b0;
    end else if (pwr_cnt_q == 24'(SPI_PWR_DELAY_CYC - 1)) begin
      pwr_ok_d = 1'b1;
    end else begin
      pwr_cnt_d = pwr_cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pwr_cnt_q <= 24'h000000;
      pwr_ok_q <= 1'b0;
    end else begin
      pwr_cnt_q <= pwr_cnt_d;
      pwr_ok_q <= pwr_ok_d;
    end
  end

  // ==========================================================
  // registers and divider
  logic [1:0] ctrl_q, ctrl_d;
  logic [31:0] len_q, len_d;
  ccs_pkg::ccs_state_t st_q, st_d;
  ccs_pkg::ccs_mode_t mode_q, mode_d;
  logic fast_q, fast_d, done_q, done_d, pio_q, pio_d;
  logic [31:0] bitcnt_q, bitcnt_d;
  logic [5:0] wake_q, wake_d;
  logic config_complete_oe_d, ss_oe_d, sck_oe_d, bit_d, vld_d, otp_next_d;
  logic hold, osc_mode, bit_tick, cfg_tick, bit_val, div_run;
  logic div_sck, div_rise, div_fall;

  // the divider stands in for the internal oscillator's serial clock
  ccs_sck_div u_div (
    .clk(CLK),
    .rst(RST),
    .run(div_run),
    .fast(fast_q),
    .sck_q(div_sck),
    .rise_q(div_rise),
    .fall_q(div_fall)
  );

  // ==========================================================
  // configuration sequencer
  always_comb begin
    hold = !cfg_rst_n_s || !sup_all_s || !pwr_ok_q;
    osc_mode = (mode_q == ccs_pkg::MODE_MASTER) ||
               (mode_q == ccs_pkg::MODE_OTP);
    // the last wake pulse finishes its high half before the divider stops
    div_run = osc_mode && (st_q == ccs_pkg::ST_LOAD ||
                           st_q == ccs_pkg::ST_WAKE ||
                           (st_q == ccs_pkg::ST_USER && div_sck));
    // data are taken on the fall, before the synchronised input shows the flash's next bit
    bit_tick = osc_mode ? div_fall : sck_rise;
    cfg_tick = osc_mode ? div_rise : sck_rise;
    bit_val = (mode_q == ccs_pkg::MODE_OTP) ? OTP_BIT : si_s;
    st_d = st_q;
    mode_d = mode_q;
    fast_d = fast_q;
    done_d = done_q;
    pio_d = pio_q;
    bitcnt_d = bitcnt_q;
    wake_d = wake_q;
    bit_d = CFG_BIT;
    vld_d = 1'b0;
    otp_next_d = 1'b0;
    if (hold) begin
      // every sequencer register except CFG_BIT returns to its power-up value
      st_d = ccs_pkg::ST_HOLD;
      mode_d = ccs_pkg::MODE_NONE;
      fast_d = 1'b0;
      done_d = 1'b0;
      pio_d = 1'b0;
      bitcnt_d = 32'h0000_0000;
      wake_d = 6'h00;
    end else begin
      case (st_q)
        ccs_pkg::ST_HOLD: begin
          st_d = ccs_pkg::ST_LOAD;
          if (!ss_s) begin
            mode_d = ccs_pkg::MODE_SLAVE;
          end else if (OTP_PROGRAMMED && ctrl_q[ccs_pkg::CTRL_OTP_EN]) begin
            mode_d = ccs_pkg::MODE_OTP;
          end else begin
            mode_d = ccs_pkg::MODE_MASTER;
          end
        end
        ccs_pkg::ST_LOAD: begin
          if (bit_tick) begin
            bit_d = bit_val;
            vld_d = 1'b1;
            otp_next_d = (mode_q == ccs_pkg::MODE_OTP);
            bitcnt_d = bitcnt_q + 32'h0000_0001;
            if (bitcnt_q == ccs_pkg::FAST_FLAG_BIT && bit_val && osc_mode &&
                !ctrl_q[ccs_pkg::CTRL_FORCE_SLOW]) begin
              fast_d = 1'b1;
            end
            if (bitcnt_d == len_q) begin
              done_d = 1'b1;
              st_d = ccs_pkg::ST_WAKE;
            end
          end
        end
        ccs_pkg::ST_WAKE: begin
          if (cfg_tick) begin
            wake_d = wake_q + 6'h01;
            if (wake_q == ccs_pkg::WAKE_CYCLES - 6'h01) begin
              pio_d = 1'b1;
              st_d = ccs_pkg::ST_USER;
            end
          end
        end
        ccs_pkg::ST_USER: begin
          st_d = ccs_pkg::ST_USER;
        end
        default: begin
          st_d = ccs_pkg::ST_HOLD;
        end
      endcase
    end
    config_complete_oe_d = !done_d;
    ss_oe_d = (st_d == ccs_pkg::ST_LOAD) &&
              (mode_d == ccs_pkg::MODE_MASTER);
    sck_oe_d = (mode_d == ccs_pkg::MODE_MASTER) &&
               (st_d == ccs_pkg::ST_LOAD ||
                st_d == ccs_pkg::ST_WAKE);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= ccs_pkg::ST_HOLD;
      mode_q <= ccs_pkg::MODE_NONE;
      fast_q <= 1'b0;
      done_q <= 1'b0;
      pio_q <= 1'b0;
      bitcnt_q <= 32'h0000_0000;
      wake_q <= 6'h00;
      CONFIG_COMPLETE_OE <= 1'b1;
      SS_OE <= 1'b0;
      SCK_OE <= 1'b0;
      CFG_BIT <= 1'b0;
      CFG_BIT_VLD <= 1'b0;
      OTP_NEXT <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      fast_q <= fast_d;
      done_q <= done_d;
      pio_q <= pio_d;
      bitcnt_q <= bitcnt_d;
      wake_q <= wake_d;
      CONFIG_COMPLETE_OE <= config_complete_oe_d;
      SS_OE <= ss_oe_d;
      SCK_OE <= sck_oe_d;
      CFG_BIT <= bit_d;
      CFG_BIT_VLD <= vld_d;
      OTP_NEXT <= otp_next_d;
    end
  end

  // open-drain pins only ever pull low; select is low while driven
  always_comb begin
    CONFIG_COMPLETE_O = 1'b0;
    SS_O = 1'b0;
    SCK_O = div_sck;
    PROGRAMMABLE_IO_EN = pio_q;
  end

  // ==========================================================
  // apb slave, one wait state
  logic pready_d, pslverr_d;
  logic [31:0] prdata_d;
  logic acc, wr;

  always_comb begin
    acc = PSEL && PENABLE && !PREADY;
    wr = PSEL && PENABLE && PREADY && PWRITE;
    pready_d = acc;
    pslverr_d = acc && !addr_hit(PADDR);
    prdata_d = 32'h0000_0000;
    ctrl_d = ctrl_q;
    len_d = len_q;
    if (acc && !PWRITE) begin
      case (PADDR)
        ccs_pkg::ADDR_CTRL: prdata_d = {30'h0, ctrl_q};
        ccs_pkg::ADDR_LEN: prdata_d = len_q;
        ccs_pkg::ADDR_STATUS: begin
          prdata_d[ccs_pkg::ST_MODE_LSB +: 2] = mode_q;
          prdata_d[ccs_pkg::ST_FAST] = fast_q;
          prdata_d[ccs_pkg::ST_DONE] = done_q;
          prdata_d[ccs_pkg::ST_PIO] = pio_q;
          prdata_d[ccs_pkg::ST_STATE_LSB +: 2] = st_q;
        end
        ccs_pkg::ADDR_BITCNT: prdata_d = bitcnt_q;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr && PADDR == ccs_pkg::ADDR_CTRL) begin
      ctrl_d = PWDATA[1:0];
    end
    if (wr && PADDR == ccs_pkg::ADDR_LEN) begin
      len_d = PWDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      ctrl_q <= ccs_pkg::CTRL_RST;
      len_q <= ccs_pkg::LEN_RST;
    end else begin
      PREADY <= pready_d;
      PSLVERR <= pslverr_d;
      PRDATA <= prdata_d;
      ctrl_q <= ctrl_d;
      len_q <= len_d;
    end
  end
endmodule : ccs_config_seq

`default_nettype wire

// [ccs_seq_asserts.sv]
/* Checker on the sequencer ports, bound onto every instance.
   Assumes one clock domain, CLK, reset by RST. */
`default_nettype none
module ccs_seq_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // pins in
  input wire logic VCC_GOOD,
  input wire logic SPI_VCC_GOOD,
  input wire logic CONFIG_RESET_N,
  // pins out
  input wire logic CONFIG_COMPLETE_O,
  input wire logic CONFIG_COMPLETE_OE,
  input wire logic SS_OE,
  input wire logic SCK_O,
  input wire logic SCK_OE,
  input wire logic PROGRAMMABLE_IO_EN
);
  // ==========================================
  // serial clock rises since completion
  logic [6:0] wk_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) wk_q <= 7'h0;
    else if (CONFIG_COMPLETE_OE) wk_q <= 7'h0;
    else if ($rose(SCK_O)) wk_q <= wk_q + 7'h1;
  end
  // ==========================================
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_fast_hi;
    SCK_O [*2] ##1 !SCK_O;
  endsequence
  sequence s_slow_hi;
    SCK_O [*4] ##1 !SCK_O;
  endsequence
  property p_pin_rst;
    !CONFIG_RESET_N [*4] |-> CONFIG_COMPLETE_OE && !PROGRAMMABLE_IO_EN;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin not holding");
  property p_supply;
    !VCC_GOOD [*4] |-> CONFIG_COMPLETE_OE && !SCK_OE;
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply loss not holding");
  property p_flash_wait; $rose(SPI_VCC_GOOD) |-> !SCK_OE [*8]; endproperty
  a_flash_wait: assert property (p_flash_wait)
    else $error("flash supply wait short");
  property p_drain; CONFIG_COMPLETE_O == 1'b0; endproperty
  a_drain: assert property (p_drain)
    else $error("done pin driven high");
  property p_io_after; PROGRAMMABLE_IO_EN |-> !CONFIG_COMPLETE_OE; endproperty
  a_io_after: assert property (p_io_after)
    else $error("io enabled before done");
  // one clock of slack either way; the count and the enable land on the same edge
  property p_io_wake;
    $rose(PROGRAMMABLE_IO_EN) && $past(SCK_OE) |->
      wk_q inside {[7'h30:7'h32]};
  endproperty
  a_io_wake: assert property (p_io_wake)
    else $error("io wake count wrong");
  property p_duty; $rose(SCK_O) |-> s_fast_hi or s_slow_hi; endproperty
  a_duty: assert property (p_duty)
    else $error("serial clock high time wrong");
  property p_sel; $rose(SS_OE) |-> SCK_OE; endproperty
  a_sel: assert property (p_sel)
    else $error("select without clock");
endmodule : ccs_seq_chk

bind ccs_config_seq ccs_seq_chk u_chk (
  .CLK(CLK), .RST(RST), .VCC_GOOD(VCC_GOOD),
  .SPI_VCC_GOOD(SPI_VCC_GOOD), .CONFIG_RESET_N(CONFIG_RESET_N),
  .CONFIG_COMPLETE_O(CONFIG_COMPLETE_O),
  .CONFIG_COMPLETE_OE(CONFIG_COMPLETE_OE), .SS_OE(SS_OE),
  .SCK_O(SCK_O), .SCK_OE(SCK_OE),
  .PROGRAMMABLE_IO_EN(PROGRAMMABLE_IO_EN)
);
`default_nettype wire

// [ccs_ser_model.sv]
/* Serial partner: flash in master mode, host in slave mode.
   Assumes pat holds the stream, bit 0 sent first. */
`default_nettype none
module ccs_ser_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic ss_oe,
  input wire logic sck_o,
  // host side
  input wire logic host_run,
  input wire logic [127:0] pat,
  output logic si,
  output logic sck_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] idx_q = 8'h0;
  logic prv_q = 1'b0;
  logic tgl_q = 1'b0;
  logic act;
  logic lclk;
  // host clock stands low between frames, 160 ns period inside
  initial begin
    sck_i = 1'b0;
    #3;
    forever #80 sck_i = host_run ? ~sck_i : 1'b0;
  end
  assign act = ss_oe || host_run;
  assign lclk = ss_oe ? sck_o : sck_i;
  // released line changes every cycle so stale bits cannot match
  assign si = act ? pat[idx_q] : tgl_q;
  always @(posedge clk) begin
    prv_q <= lclk;
    tgl_q <= ~tgl_q;
    if (!act) idx_q <= 8'h0;
    else if (prv_q && !lclk) idx_q <= idx_q + 8'h1;
  end
endmodule : ccs_ser_model
`default_nettype wire

// [ccs_config_seq_tb_top.sv]
/* Bench for ccs_config_seq: APB master, serial partner, OTP source.
   Assumes the package is compiled first and the checker is bound. */
`default_nettype none
module ccs_config_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, PREADY, PSLVERR, SS_O, SS_OE, SCK_O, SCK_OE;
  logic [7:0] PADDR = 8'h0, oi = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  // reset pin starts low so no load runs before the first scenario
  logic CONFIG_RESET_N = 1'b0, ss_drv = 1'b1, OTP_PROGRAMMED = 1'b0;
  logic CONFIG_COMPLETE_O, CONFIG_COMPLETE_OE, OTP_NEXT, SI, sck_h;
  logic CFG_BIT, CFG_BIT_VLD, PROGRAMMABLE_IO_EN, host = 1'b0;
  logic [3:0] pg = 4'hf;
  logic [127:0] pat = 128'h0;
  int fails = 0, n_compared = 0, bi = 0, len = 0;
  // shared pins: the device wins while enabled, otherwise a pull-up on done and the bench on select and clock
  wire logic done_w = CONFIG_COMPLETE_OE ? CONFIG_COMPLETE_O : 1'b1;
  wire logic ss_w = SS_OE ? SS_O : ss_drv;
  wire logic sck_w = SCK_OE ? SCK_O : sck_h;
  always #5 CLK = ~CLK;
  ccs_config_seq #(.SPI_PWR_DELAY_CYC(20)) DUT (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .VCC_GOOD(pg[0]),
    .SPI_VCC_GOOD(pg[1]), .IO_VCC_GOOD(pg[2]), .VPP_GOOD(pg[3]),
    .CONFIG_RESET_N(CONFIG_RESET_N), .CONFIG_COMPLETE_O(CONFIG_COMPLETE_O),
    .CONFIG_COMPLETE_OE(CONFIG_COMPLETE_OE), .SS_I(ss_w), .SS_O(SS_O),
    .SS_OE(SS_OE), .SCK_I(sck_w), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
    .SI(SI), .OTP_PROGRAMMED(OTP_PROGRAMMED), .OTP_BIT(pat[oi]),
    .OTP_NEXT(OTP_NEXT), .CFG_BIT(CFG_BIT), .CFG_BIT_VLD(CFG_BIT_VLD),
    .PROGRAMMABLE_IO_EN(PROGRAMMABLE_IO_EN)
  );
  ccs_ser_model u_ser (
    .clk(CLK), .ss_oe(SS_OE), .sck_o(SCK_O), .host_run(host),
    .pat(pat), .si(SI), .sck_i(sck_h)
  );
  // ==========================================
  // checks and bus cycles
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wait_st(input logic [1:0] st);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    r = 32'h0;
    while (r[9:8] !== st && n < 500) begin
      apb(1'b0, ccs_pkg::ADDR_STATUS, 32'h0, r, e);
      n++;
    end
    chk("state", {22'h0, st, 8'h0}, r & 32'h300);
  endtask : wait_st
  // every taken bit must be the next stream bit until the length
  always @(posedge CLK) begin
    if (OTP_NEXT === 1'b1) oi <= oi + 8'h1;
    if (CFG_BIT_VLD === 1'b1 && bi < len) begin
      chk("cfg bit", pat[bi], CFG_BIT);
      bi <= bi + 1;
    end
  end
  task automatic run_cfg(input logic [1:0] m, input logic slow);
    logic [31:0] r;
    logic e;
    int n;
    pat = {$urandom, $urandom, $urandom, $urandom};
    pat[7] = m[0];
    n = 16 + $urandom % 25;
    apb(1'b1, ccs_pkg::ADDR_LEN, n, r, e);
    // forcing slow also drops the memory enable: flash despite memory
    apb(1'b1, ccs_pkg::ADDR_CTRL, {30'h0, slow, !slow}, r, e);
    ss_drv <= (m != 2'h3);
    OTP_PROGRAMMED <= (m == 2'h2) || slow;
    CONFIG_RESET_N <= 1'b0;
    repeat (6) @(posedge CLK);
    chk("done pin low", 32'h0, done_w);
    // bit checking starts only once any older stream is held off
    bi = 0;
    len = n;
    oi <= 8'h0;
    CONFIG_RESET_N <= 1'b1;
    wait_st(2'h1);
    apb(1'b0, ccs_pkg::ADDR_STATUS, 32'h0, r, e);
    chk("mode", m, r[1:0]);
    host <= (m == 2'h3);
    wait_st(2'h3);
    host <= 1'b0;
    chk("bits", len, bi);
    chk("done pin high", 32'h1, done_w);
    chk("io", 32'h1, PROGRAMMABLE_IO_EN);
    apb(1'b0, ccs_pkg::ADDR_BITCNT, 32'h0, r, e);
    chk("bitcnt", len, r);
    apb(1'b0, ccs_pkg::ADDR_STATUS, 32'h0, r, e);
    chk("status", {29'h3, m == 2'h1 && !slow}, r[4:2]);
  endtask : run_cfg
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    int k;
    void'($urandom(85));
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, ccs_pkg::ADDR_CTRL, 32'h0, r, e);
    chk("ctrl", ccs_pkg::CTRL_RST, r);
    apb(1'b0, ccs_pkg::ADDR_LEN, 32'h0, r, e);
    chk("len", ccs_pkg::LEN_RST, r);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped", 32'h1, {r[30:0], e});
    run_cfg(2'h1, 1'b0);
    run_cfg(2'h2, 1'b0);
    run_cfg(2'h1, 1'b1);
    // slave last: the supply checks below must find no serial clock running
    run_cfg(2'h3, 1'b0);
    for (k = 0; k < 4; k++) begin
      pg[k] <= 1'b0;
      repeat (6) @(posedge CLK);
      chk("supply hold", 32'h0, {PROGRAMMABLE_IO_EN, done_w});
      pg[k] <= 1'b1;
      if (k == 1) begin
        // flash supply timeout of 20 cycles plus sync is still running here
        repeat (12) @(posedge CLK);
        apb(1'b0, ccs_pkg::ADDR_STATUS, 32'h0, r, e);
        chk("flash wait", 32'h0, r & 32'h300);
      end
      wait_st(2'h1);
    end
    complete_run;
  end
  // four loads and the supply checks need under 10000 cycles
  initial begin
    #300000;
    fails++;
    complete_run;
  end
endmodule : ccs_config_seq_tb_top
`default_nettype wire
